// [design/ubk_top.sv]
// two-channel user break comparator with sequence, count, resume address and axi4-lite registers
//
// Behaviour
// - sequence enable and select bits per channel
// - sequence works ch0 then ch1 or reverse
// - each channel sets its flag on match
// - clearing first flag disarms the sequence
// - channel 1 count joins sequence condition
// - near-simultaneous sequence matches not ordered
// - resume address saved before exception entry
// - pre-fetch break saves matching instruction address
// - pre-fetch in slot saves branch address
// - post-fetch saves next or branch target
// - operand address break saves next or target
// - data operand break lands one to six later
// - branch after data match defers past slot
// - debug enable vectors to debug base register
// - set mask bits drop address bits from compare
// - odd fetch match address never breaks
// - count N breaks before Nth execution
// - address space id must equal when enabled
// - flags stay set until software writes zero
// - block bit drops requests, flags still set
// - simultaneous matches give one request only
`include "ubk_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module ubk_top (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // cpu core watch ports
  input  wire logic        fetch_exec_in,
  input  wire logic [31:0] fetch_addr_in,
  input  wire logic        fetch_slot_in,
  input  wire logic [31:0] fetch_branch_addr_in,
  input  wire logic        opnd_valid_in,
  input  wire logic [31:0] opnd_addr_in,
  input  wire logic [31:0] opnd_data_in,
  input  wire logic        retire_in,
  input  wire logic        retire_branch_in,
  input  wire logic [31:0] retire_next_addr_in,
  input  wire logic [7:0]  address_space_id_in,
  input  wire logic        cpu_block_bit_in,
  input  wire logic [31:0] vector_base_register_in,
  // break request to exception logic
  output logic             break_req_out,
  output logic             break_pre_out,
  output logic [31:0]      saved_program_counter_out,
  output logic [31:0]      break_vector_out
);

  // ****************************************
  // registers
  // ****************************************
  ubk_pkg::ubk_word_t cond_cfg [2];
  ubk_pkg::ubk_word_t act_cfg [2];
  ubk_pkg::ubk_word_t match_addr [2];
  ubk_pkg::ubk_word_t match_mask [2];
  ubk_pkg::ubk_word_t match_data_ch1;
  ubk_pkg::ubk_word_t match_data_mask_ch1;
  ubk_pkg::ubk_word_t execution_count_ch1;
  ubk_pkg::ubk_word_t break_control_register;
  ubk_pkg::ubk_word_t debug_base_register;
  logic [1:0]         match_flags;
  ubk_pkg::ubk_word_t exec_seen;
  logic               late_pend;
  logic [1:0]         hit_raw;
  logic [1:0]         hit;
  logic [1:0]         seq_ok;
  logic [1:0]         req;
  logic [1:0]         pre_req;
  logic [1:0]         late_req;
  logic               cnt_ok;
  logic               wr_go;
  logic               rd_go;
  logic               fire_pre;
  logic               fire_late;
  logic               late_now;
  logic               flags_wr;
  logic               count_wr;
  logic [1:0]         next_flags;
  ubk_pkg::ubk_word_t rd_word;
  logic               rd_hit;
  ubk_pkg::ubk_word_t bmask;

  // ****************************************
  // per channel comparators
  // ****************************************
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      logic addr_eq;
      logic address_space_id_ok;
      logic data_ok;
      logic fetch_hit;
      logic opnd_hit;
      logic seq_act;
      // mask bit set removes that address bit from the compare
      assign addr_eq = (((cond_cfg[c][`UBK_CC_OPND] ? opnd_addr_in : fetch_addr_in) ^ match_addr[c])
                       & ~match_mask[c]) == `UBK_RST_WORD;
      assign address_space_id_ok = ~cond_cfg[c][`UBK_CC_ASIDEN] |
                       (address_space_id_in == cond_cfg[c][`UBK_CC_ADDRESS_SPACE_ID_MSB:`UBK_CC_ADDRESS_SPACE_ID_LSB]);
      // only channel 1 owns data compare
      assign data_ok = (c == 0) | ~cond_cfg[c][`UBK_CC_DATA] |
                       (((opnd_data_in ^ match_data_ch1) & ~match_data_mask_ch1) == `UBK_RST_WORD);
      // fetches are always even, so an odd match address can never give a fetch hit
      assign fetch_hit = fetch_exec_in & ~cond_cfg[c][`UBK_CC_OPND] & ~match_addr[c][0];
      assign opnd_hit = opnd_valid_in & cond_cfg[c][`UBK_CC_OPND] & data_ok;
      assign hit_raw[c] = cond_cfg[c][`UBK_CC_EN] & addr_eq & address_space_id_ok & (fetch_hit | opnd_hit);
      // count condition is part of channel 1 match, so it also gates sequence use
      assign hit[c] = hit_raw[c] & ((c == 0) | ~cond_cfg[c][`UBK_CC_CNT] | cnt_ok);
      // second channel of a sequence names the first in its select bit
      assign seq_act = cond_cfg[c][`UBK_CC_SEQ] & (cond_cfg[c][`UBK_CC_SEL] != 1'(c));
      // the second channel is armed by the first channel's flag from an earlier cycle only
      assign seq_ok[c] = ~seq_act | match_flags[1 - c];
      assign req[c] = hit[c] & seq_ok[c] & act_cfg[c][`UBK_CA_BIE];
      assign pre_req[c] = req[c] & ~cond_cfg[c][`UBK_CC_OPND] & ~act_cfg[c][`UBK_CA_POST];
      assign late_req[c] = req[c] & (cond_cfg[c][`UBK_CC_OPND] | act_cfg[c][`UBK_CA_POST]);
    end
  endgenerate

  // count N: break on the Nth hit, after N-1 have run
  assign cnt_ok = (exec_seen == (execution_count_ch1 - 32'h00000001));

  // ****************************************
  // break firing
  // ****************************************
  assign late_now = |late_req;
  // block bit drops requests; pre wins when both land together
  assign fire_pre = |pre_req & ~cpu_block_bit_in;
  // late breaks wait for a non-branch retire so branch and slot finish first
  assign fire_late = ~fire_pre & ~cpu_block_bit_in & (late_pend | late_now) &
                     retire_in & ~retire_branch_in;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      late_pend <= 1'b0;
    end else if (fire_pre | fire_late | cpu_block_bit_in) begin
      late_pend <= 1'b0;
    end else if (late_now) begin
      late_pend <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      break_req_out             <= 1'b0;
      break_pre_out             <= 1'b0;
      saved_program_counter_out <= `UBK_RST_WORD;
    end else begin
      break_req_out <= fire_pre | fire_late;
      break_pre_out <= fire_pre;
      if (fire_pre) begin
        // matching instruction does not run; a slot restarts at its branch
        saved_program_counter_out <= fetch_slot_in ? fetch_branch_addr_in : fetch_addr_in;
      end else if (fire_late) begin
        saved_program_counter_out <= retire_next_addr_in;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      break_vector_out <= `UBK_RST_WORD;
    end else begin
      break_vector_out <= break_control_register[`UBK_BC_DBG] ? debug_base_register :
                          vector_base_register_in + `UBK_BREAK_OFS;
    end
  end

  // ****************************************
  // execution counter
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      exec_seen <= `UBK_RST_WORD;
    end else if (count_wr | hit[1]) begin
      exec_seen <= `UBK_RST_WORD;
    end else if (hit_raw[1] & cond_cfg[1][`UBK_CC_CNT]) begin
      exec_seen <= exec_seen + 32'h00000001;
    end
  end

  // ****************************************
  // match flags
  // ****************************************
  assign flags_wr = wr_go & (s_axi_awaddr_in == `UBK_OFF_FLAGS) & s_axi_wstrb_in[0];
  assign count_wr = wr_go & (s_axi_awaddr_in == `UBK_OFF_COUNT1);

  always_comb begin
    next_flags = match_flags;
    if (flags_wr) begin
      next_flags = match_flags & s_axi_wdata_in[1:0];
    end
    // a hit in the clearing cycle still sets the flag
    next_flags = next_flags | hit;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      match_flags <= 2'h0;
    end else begin
      match_flags <= next_flags;
    end
  end

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  // both valids waited for, taken in one cycle
  assign wr_go = s_axi_awvalid_in & s_axi_awready_out & s_axi_wvalid_in & s_axi_wready_out;
  assign bmask = {{8{s_axi_wstrb_in[3]}}, {8{s_axi_wstrb_in[2]}}, {8{s_axi_wstrb_in[1]}}, {8{s_axi_wstrb_in[0]}}};

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `UBK_RESP_OKAY;
    end else begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      if (wr_go) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= (s_axi_awaddr_in > `UBK_OFF_DBASE || s_axi_awaddr_in[1:0] != 2'h0) ?
                            `UBK_RESP_SLVERR : `UBK_RESP_OKAY;
      end else if (s_axi_bvalid_out & s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end else if (s_axi_awvalid_in & s_axi_wvalid_in & ~s_axi_awready_out & ~s_axi_bvalid_out) begin
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cond_cfg[0]            <= `UBK_RST_WORD;
      cond_cfg[1]            <= `UBK_RST_WORD;
      act_cfg[0]             <= `UBK_RST_WORD;
      act_cfg[1]             <= `UBK_RST_WORD;
      match_addr[0]          <= `UBK_RST_WORD;
      match_addr[1]          <= `UBK_RST_WORD;
      match_mask[0]          <= `UBK_RST_WORD;
      match_mask[1]          <= `UBK_RST_WORD;
      match_data_ch1         <= `UBK_RST_WORD;
      match_data_mask_ch1    <= `UBK_RST_WORD;
      execution_count_ch1    <= `UBK_RST_WORD;
      break_control_register <= `UBK_RST_WORD;
      debug_base_register    <= `UBK_RST_WORD;
    end else if (wr_go) begin
      case (s_axi_awaddr_in)
        `UBK_OFF_COND0: cond_cfg[0] <= (cond_cfg[0] & ~bmask) | (s_axi_wdata_in & bmask);
        `UBK_OFF_COND1: cond_cfg[1] <= (cond_cfg[1] & ~bmask) | (s_axi_wdata_in & bmask);
        `UBK_OFF_ACT0:  act_cfg[0] <= (act_cfg[0] & ~bmask) | (s_axi_wdata_in & bmask);
        `UBK_OFF_ACT1:  act_cfg[1] <= (act_cfg[1] & ~bmask) | (s_axi_wdata_in & bmask);
        `UBK_OFF_ADDR0: match_addr[0] <= (match_addr[0] & ~bmask) | (s_axi_wdata_in & bmask);
        `UBK_OFF_ADDR1: match_addr[1] <= (match_addr[1] & ~bmask) | (s_axi_wdata_in & bmask);
        `UBK_OFF_AMASK0: match_mask[0] <= (match_mask[0] & ~bmask) | (s_axi_wdata_in & bmask);
        `UBK_OFF_AMASK1: match_mask[1] <= (match_mask[1] & ~bmask) | (s_axi_wdata_in & bmask);
        `UBK_OFF_DATA1: match_data_ch1 <= (match_data_ch1 & ~bmask) | (s_axi_wdata_in & bmask);
        `UBK_OFF_DMASK1: match_data_mask_ch1 <= (match_data_mask_ch1 & ~bmask) | (s_axi_wdata_in & bmask);
        `UBK_OFF_COUNT1: execution_count_ch1 <= (execution_count_ch1 & ~bmask) | (s_axi_wdata_in & bmask);
        `UBK_OFF_BCTRL: break_control_register <= (break_control_register & ~bmask) | (s_axi_wdata_in & bmask);
        `UBK_OFF_DBASE: debug_base_register <= (debug_base_register & ~bmask) | (s_axi_wdata_in & bmask);
        default: ;
      endcase
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  assign rd_go = s_axi_arvalid_in & s_axi_arready_out;

  always_comb begin
    rd_word = `UBK_RST_WORD;
    rd_hit  = 1'b1;
    case (s_axi_araddr_in)
      `UBK_OFF_COND0:  rd_word = cond_cfg[0];
      `UBK_OFF_COND1:  rd_word = cond_cfg[1];
      `UBK_OFF_ACT0:   rd_word = act_cfg[0];
      `UBK_OFF_ACT1:   rd_word = act_cfg[1];
      `UBK_OFF_ADDR0:  rd_word = match_addr[0];
      `UBK_OFF_ADDR1:  rd_word = match_addr[1];
      `UBK_OFF_AMASK0: rd_word = match_mask[0];
      `UBK_OFF_AMASK1: rd_word = match_mask[1];
      `UBK_OFF_DATA1:  rd_word = match_data_ch1;
      `UBK_OFF_DMASK1: rd_word = match_data_mask_ch1;
      `UBK_OFF_COUNT1: rd_word = execution_count_ch1;
      `UBK_OFF_BCTRL:  rd_word = break_control_register;
      `UBK_OFF_FLAGS:  rd_word = {30'h0, match_flags};
      `UBK_OFF_DBASE:  rd_word = debug_base_register;
      default:         rd_hit  = 1'b0;
    endcase
  end

  // address is taken one cycle, data answered the next
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= `UBK_RST_WORD;
      s_axi_rresp_out   <= `UBK_RESP_OKAY;
    end else begin
      s_axi_arready_out <= 1'b0;
      if (s_axi_rvalid_out & s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end else if (rd_go) begin
        s_axi_rvalid_out <= 1'b1;
      end else if (s_axi_arvalid_in & ~s_axi_arready_out & ~s_axi_rvalid_out) begin
        s_axi_arready_out <= 1'b1;
      end
      if (rd_go) begin
        s_axi_rdata_out <= rd_word;
        s_axi_rresp_out <= rd_hit ? `UBK_RESP_OKAY : `UBK_RESP_SLVERR;
      end
    end
  end

endmodule
`default_nettype wire

// [include/ubk_cfg.svh]
// register offsets, field positions, reset values and constants of the user break block
`ifndef UBK_CFG_SVH
`define UBK_CFG_SVH
// ****************************************
// register byte offsets
// ****************************************
`define UBK_OFF_COND0   8'h00
`define UBK_OFF_COND1   8'h04
`define UBK_OFF_ACT0    8'h08
`define UBK_OFF_ACT1    8'h0C
`define UBK_OFF_ADDR0   8'h10
`define UBK_OFF_ADDR1   8'h14
`define UBK_OFF_AMASK0  8'h18
`define UBK_OFF_AMASK1  8'h1C
`define UBK_OFF_DATA1   8'h20
`define UBK_OFF_DMASK1  8'h24
`define UBK_OFF_COUNT1  8'h28
`define UBK_OFF_BCTRL   8'h2C
`define UBK_OFF_FLAGS   8'h30
`define UBK_OFF_DBASE   8'h34
// ****************************************
// field positions
// ****************************************
`define UBK_CC_EN       0
`define UBK_CC_OPND     1
`define UBK_CC_DATA     2
`define UBK_CC_CNT      3
`define UBK_CC_ASIDEN   4
`define UBK_CC_ADDRESS_SPACE_ID_LSB 8
`define UBK_CC_ADDRESS_SPACE_ID_MSB 15
`define UBK_CC_SEL      30
`define UBK_CC_SEQ      31
`define UBK_CA_BIE      0
`define UBK_CA_POST     1
`define UBK_BC_DBG      0
// ****************************************
// reset values and constants
// ****************************************
`define UBK_RST_WORD    32'h00000000
`define UBK_BREAK_OFS   32'h00000100
`define UBK_RESP_OKAY   2'h0
`define UBK_RESP_SLVERR 2'h2
`endif

// [include/ubk_pkg.sv]
// types shared by the user break block
package ubk_pkg;
  typedef logic [31:0] ubk_word_t;
  typedef enum logic [1:0] {
    UBK_KIND_NONE = 2'h0,
    UBK_KIND_PRE  = 2'h1,
    UBK_KIND_POST = 2'h3
  } ubk_kind_t;
endpackage

// [bench/ubk_top_chk.sv]
// port-level assertions for the user break block
`timescale 1ns/10ps
`default_nettype none
module ubk_top_chk (
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic        fetch_exec_in,
  input wire logic [31:0] fetch_addr_in,
  input wire logic        fetch_slot_in,
  input wire logic [31:0] fetch_branch_addr_in,
  input wire logic        retire_in,
  input wire logic        retire_branch_in,
  input wire logic [31:0] retire_next_addr_in,
  input wire logic        cpu_block_bit_in,
  input wire logic        break_req_out,
  input wire logic        break_pre_out,
  input wire logic [31:0] saved_program_counter_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // ****************************************
  // break request and resume address
  // ****************************************
  one_request_a: assert property (break_req_out |=> !break_req_out)
    else $error("break request longer than one cycle");
  blocked_req_a: assert property (cpu_block_bit_in |=> !break_req_out)
    else $error("break request while block bit set");
  pre_cause_a: assert property (break_pre_out |-> break_req_out && $past(fetch_exec_in))
    else $error("pre break without a fetch before it");
  pre_resume_a: assert property (break_req_out && break_pre_out |->
    saved_program_counter_out == ($past(fetch_slot_in) ? $past(fetch_branch_addr_in) : $past(fetch_addr_in)))
    else $error("pre break resume address wrong");
  late_resume_a: assert property (break_req_out && !break_pre_out |->
    saved_program_counter_out == $past(retire_next_addr_in))
    else $error("late break resume address wrong");
  late_cause_a: assert property (break_req_out && !break_pre_out |->
    $past(retire_in) && !$past(retire_branch_in))
    else $error("late break not after a plain retire");
  resume_hold_a: assert property (!break_req_out |-> $stable(saved_program_counter_out))
    else $error("resume address moved without a break");
  req_cause_a: assert property (break_req_out |-> $past(fetch_exec_in) || $past(retire_in))
    else $error("break request with no fetch or retire");
endmodule
bind ubk_top ubk_top_chk u_chk (.sys_clk_in, .rst_in, .fetch_exec_in, .fetch_addr_in, .fetch_slot_in,
  .fetch_branch_addr_in, .retire_in, .retire_branch_in, .retire_next_addr_in, .cpu_block_bit_in,
  .break_req_out, .break_pre_out, .saved_program_counter_out);
`default_nettype wire

// [bench/ubk_cpu_model.sv]
// cpu core model driving the watch ports of the user break block
`timescale 1ns/10ps
`default_nettype none
module ubk_cpu_model #(
  parameter logic [31:0] VBASE = 32'h80000000
) (
  input  wire logic        sys_clk_in,
  input  wire logic        break_req_in,
  input  wire logic        break_pre_in,
  output logic             fetch_exec_out,
  output logic [31:0]      fetch_addr_out,
  output logic             fetch_slot_out,
  output logic [31:0]      fetch_branch_addr_out,
  output logic             opnd_valid_out,
  output logic [31:0]      opnd_addr_out,
  output logic [31:0]      opnd_data_out,
  output logic             retire_out,
  output logic             retire_branch_out,
  output logic [31:0]      retire_next_addr_out,
  output logic [7:0]       address_space_id_out,
  output logic             cpu_block_bit_out,
  output wire logic [31:0] vector_base_out
);
  // ****************************************
  // one instruction at a time
  // ****************************************
  assign vector_base_out = VBASE;
  initial begin
    {fetch_exec_out, fetch_slot_out, opnd_valid_out, retire_out, retire_branch_out, cpu_block_bit_out} = 6'h00;
    {fetch_addr_out, fetch_branch_addr_out, opnd_addr_out, opnd_data_out, retire_next_addr_out} = 160'h0;
    address_space_id_out = 8'h00;
  end
  // fetch, operand access, retire; released buses show the inverse so stale values cannot match
  task automatic run(input logic [31:0] a, input logic sl, input logic br, input logic [31:0] nx,
                     input logic op, input logic [31:0] oa);
    @(posedge sys_clk_in);
    fetch_exec_out <= 1'b1;
    fetch_addr_out <= a;
    fetch_slot_out <= sl;
    fetch_branch_addr_out <= a - 32'h2;
    @(posedge sys_clk_in);
    fetch_exec_out <= 1'b0;
    fetch_addr_out <= ~a;
    fetch_branch_addr_out <= ~(a - 32'h2);
    opnd_valid_out <= op;
    opnd_addr_out <= oa;
    opnd_data_out <= 32'h0000A512;
    @(posedge sys_clk_in);
    opnd_valid_out <= 1'b0;
    opnd_addr_out <= ~oa;
    opnd_data_out <= 32'hFFFF5AED;
    retire_out <= !(break_req_in && break_pre_in);
    retire_branch_out <= br;
    retire_next_addr_out <= nx;
    @(posedge sys_clk_in);
    retire_out <= 1'b0;
    retire_next_addr_out <= ~nx;
  endtask
  task automatic set_state(input logic [7:0] id, input logic blk);
    @(posedge sys_clk_in);
    address_space_id_out <= id;
    cpu_block_bit_out <= blk;
  endtask
endmodule
`default_nettype wire

// [bench/ubk_tb_top.sv]
// self-checking bench for the user break block
`include "ubk_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module ubk_tb_top;
  logic        sys_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  wire logic   awready, wready, bvalid, arready, rvalid, brk, pre, c_fe, c_fs, c_ov, c_rt, c_rb, c_blk;
  wire logic [1:0]  bresp, rresp;
  wire logic [7:0]  c_id;
  wire logic [31:0] rdata, rpc, vec, vbase, c_fa, c_fb, c_oa, c_od, c_rn;
  int          failures = 0;
  int          checks = 0;
  int          nbrk = 0;
  logic [31:0] bpc = 32'h0;
  logic        bpre = 1'b0;
  always #5 sys_clk_in = ~sys_clk_in;
  ubk_top u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .fetch_exec_in(c_fe), .fetch_addr_in(c_fa), .fetch_slot_in(c_fs), .fetch_branch_addr_in(c_fb),
    .opnd_valid_in(c_ov), .opnd_addr_in(c_oa), .opnd_data_in(c_od), .retire_in(c_rt),
    .retire_branch_in(c_rb), .retire_next_addr_in(c_rn), .address_space_id_in(c_id),
    .cpu_block_bit_in(c_blk), .vector_base_register_in(vbase), .break_req_out(brk),
    .break_pre_out(pre), .saved_program_counter_out(rpc), .break_vector_out(vec));
  ubk_cpu_model u_cpu (.sys_clk_in(sys_clk_in), .break_req_in(brk), .break_pre_in(pre),
    .fetch_exec_out(c_fe), .fetch_addr_out(c_fa), .fetch_slot_out(c_fs), .fetch_branch_addr_out(c_fb),
    .opnd_valid_out(c_ov), .opnd_addr_out(c_oa), .opnd_data_out(c_od), .retire_out(c_rt),
    .retire_branch_out(c_rb), .retire_next_addr_out(c_rn), .address_space_id_out(c_id),
    .cpu_block_bit_out(c_blk), .vector_base_out(vbase));
  // ****************************************
  // tasks
  // ****************************************
  always @(posedge sys_clk_in) begin
    if (brk === 1'b1) begin
      nbrk = nbrk + 1;
      bpc = rpc;
      bpre = pre;
    end
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `UBK_RESP_OKAY);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    cmp("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (arready === 1'b1) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    cmp(what, exp, rdata);
    cmp("rresp", {30'h0, er}, {30'h0, rresp});
  endtask
  // one channel setup
  task automatic cfg(input logic ch, input logic [31:0] cnd, input logic [31:0] act, input logic [31:0] adr);
    wr(`UBK_OFF_COND0 + {5'h0, ch, 2'h0}, cnd);
    wr(`UBK_OFF_ACT0 + {5'h0, ch, 2'h0}, act);
    wr(`UBK_OFF_ADDR0 + {5'h0, ch, 2'h0}, adr);
  endtask
  task automatic ins(input logic [31:0] a, input logic [31:0] nx, input logic sl, input logic br,
                     input logic op, input logic [31:0] oa, input logic nb, input logic [31:0] pc);
    nbrk = 0;
    u_cpu.run(a, sl, br, nx, op, oa);
    repeat (3) @(posedge sys_clk_in);
    cmp("break count", {31'h0, nb}, nbrk[31:0]);
    if (nb) cmp("resume address", pc, bpc);
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    #100000; // about twenty times the expected run
    failures++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rd_chk("cond0", `UBK_OFF_COND0, `UBK_RST_WORD, `UBK_RESP_OKAY);
    rd_chk("flags", `UBK_OFF_FLAGS, `UBK_RST_WORD, `UBK_RESP_OKAY);
    rd_chk("unmapped", 8'h38, 32'h0, `UBK_RESP_SLVERR);
    wr(8'h38, 32'h1, `UBK_RESP_SLVERR);
    cfg(1'b0, 32'h1, 32'h1, 32'h27128);
    ins(32'h27128, 32'h2712A, 1'b0, 1'b0, 1'b0, 32'h0, 1'b1, 32'h27128);
    cmp("pre kind", 32'h1, {31'h0, bpre});
    cmp("vector", vbase + `UBK_BREAK_OFS, vec);
    wr(`UBK_OFF_DBASE, 32'h00A00000);
    wr(`UBK_OFF_BCTRL, 32'h1);
    ins(32'h27128, 32'h2712A, 1'b1, 1'b0, 1'b0, 32'h0, 1'b1, 32'h27126);
    cmp("debug vector", 32'h00A00000, vec);
    wr(`UBK_OFF_BCTRL, 32'h0);
    rd_chk("flag ch0", `UBK_OFF_FLAGS, 32'h1, `UBK_RESP_OKAY);
    wr(`UBK_OFF_FLAGS, 32'h0);
    rd_chk("flag cleared", `UBK_OFF_FLAGS, 32'h0, `UBK_RESP_OKAY);
    wr(`UBK_OFF_ADDR0, 32'h31415);
    ins(32'h31415, 32'h31416, 1'b0, 1'b0, 1'b0, 32'h0, 1'b0, 32'h0);
    wr(`UBK_OFF_ADDR0, 32'h8010);
    wr(`UBK_OFF_AMASK0, 32'h6);
    for (int i = 0; i < 5; i++) begin
      ins(32'h8010 + 32'(2 * i), 32'h0, 1'b0, 1'b0, 1'b0, 32'h0, i < 4, 32'h8010 + 32'(2 * i));
    end
    wr(`UBK_OFF_AMASK0, 32'h0);
    cfg(1'b0, 32'h1, 32'h3, 32'h404);
    ins(32'h404, 32'h406, 1'b0, 1'b0, 1'b0, 32'h0, 1'b1, 32'h406);
    cmp("post kind", 32'h0, {31'h0, bpre});
    ins(32'h404, 32'h406, 1'b0, 1'b1, 1'b0, 32'h0, 1'b0, 32'h0);
    ins(32'h406, 32'h900, 1'b1, 1'b0, 1'b0, 32'h0, 1'b1, 32'h900);
    cfg(1'b0, 32'h3, 32'h1, 32'h1000);
    ins(32'h500, 32'h502, 1'b0, 1'b0, 1'b1, 32'h1000, 1'b1, 32'h502);
    cfg(1'b0, 32'h0, 32'h0, 32'h0);
    cfg(1'b1, 32'h7, 32'h1, 32'h2000);
    wr(`UBK_OFF_DATA1, 32'h0000A512);
    ins(32'h600, 32'h602, 1'b0, 1'b1, 1'b1, 32'h2000, 1'b0, 32'h0);
    ins(32'h602, 32'h880, 1'b1, 1'b0, 1'b0, 32'h0, 1'b1, 32'h880);
    cfg(1'b1, 32'h9, 32'h1, 32'h1000);
    wr(`UBK_OFF_COUNT1, 32'h5);
    for (int i = 1; i <= 5; i++) begin
      ins(32'h1000, 32'h1002, 1'b0, 1'b0, 1'b0, 32'h0, i == 5, 32'h1000);
    end
    cfg(1'b1, 32'h0, 32'h0, 32'h0);
    cfg(1'b0, 32'h8011, 32'h1, 32'h37226);
    u_cpu.set_state(8'h70, 1'b0);
    ins(32'h37226, 32'h37228, 1'b0, 1'b0, 1'b0, 32'h0, 1'b0, 32'h0);
    u_cpu.set_state(8'h80, 1'b0);
    ins(32'h37226, 32'h37228, 1'b0, 1'b0, 1'b0, 32'h0, 1'b1, 32'h37226);
    // blocked: flag set, no request
    wr(`UBK_OFF_FLAGS, 32'h0);
    u_cpu.set_state(8'h80, 1'b1);
    ins(32'h37226, 32'h37228, 1'b0, 1'b0, 1'b0, 32'h0, 1'b0, 32'h0);
    rd_chk("flag blocked", `UBK_OFF_FLAGS, 32'h1, `UBK_RESP_OKAY);
    u_cpu.set_state(8'h80, 1'b0);
    cfg(1'b0, 32'h1, 32'h0, 32'h37226);
    cfg(1'b1, 32'h80000001, 32'h1, 32'h3722E);
    wr(`UBK_OFF_FLAGS, 32'h0);
    ins(32'h3722E, 32'h37230, 1'b0, 1'b0, 1'b0, 32'h0, 1'b0, 32'h0);
    ins(32'h37226, 32'h37228, 1'b0, 1'b0, 1'b0, 32'h0, 1'b0, 32'h0);
    ins(32'h3722E, 32'h37230, 1'b0, 1'b0, 1'b0, 32'h0, 1'b1, 32'h3722E);
    rd_chk("seq flags", `UBK_OFF_FLAGS, 32'h3, `UBK_RESP_OKAY);
    wr(`UBK_OFF_FLAGS, 32'h0);
    ins(32'h3722E, 32'h37230, 1'b0, 1'b0, 1'b0, 32'h0, 1'b0, 32'h0);
    cfg(1'b1, 32'h1, 32'h0, 32'h3722E);
    cfg(1'b0, 32'hC0000001, 32'h1, 32'h37226);
    wr(`UBK_OFF_FLAGS, 32'h0);
    ins(32'h37226, 32'h37228, 1'b0, 1'b0, 1'b0, 32'h0, 1'b0, 32'h0);
    ins(32'h3722E, 32'h37230, 1'b0, 1'b0, 1'b0, 32'h0, 1'b0, 32'h0);
    ins(32'h37226, 32'h37228, 1'b0, 1'b0, 1'b0, 32'h0, 1'b1, 32'h37226);
    summarize();
  end
endmodule
`default_nettype wire
